// ### rsa_defines.svh
// Offsets, field layout, reset values and codes for the rail strobe map.
// Included by the strobe decode and strobe-assignment modules and the bench; definitions only.
`ifndef RSA_DEFINES_SVH
`define RSA_DEFINES_SVH

// Register addresses on the register access port
`define RSA_ADDR_CONV_PAIR 8'h19
`define RSA_ADDR_CONV_REG 8'h1A

// Writable bits: converter field MSBs are read-only zero
`define RSA_MASK_CONV_PAIR 8'h77
`define RSA_MASK_CONV_REG 8'h7F

// Default reset values of the two registers
`define RSA_RESET_CONV_PAIR 8'h12
`define RSA_RESET_CONV_REG 8'h3B

// Field positions: upper nibble and lower nibble
`define RSA_HI_MSB 7
`define RSA_HI_LSB 4
`define RSA_LO_MSB 3
`define RSA_LO_LSB 0

// Linear regulator codes that leave the rail outside sequencer control
`define RSA_CODE_NONE 4'h0
`define RSA_CODE_NONE_8 4'h8
`define RSA_CODE_NONE_9 4'h9

// Rail index in the rail enable vector
`define RSA_RAIL_BUCK1 0
`define RSA_RAIL_BUCK2 1
`define RSA_RAIL_BUCK3 2
`define RSA_RAIL_LINREG 3

// Value returned for a read of an unmapped address
`define RSA_UNMAPPED_DATA 8'h00

`endif

// ### rsa_pkg.sv
// Types for the rail strobe assignment block.
// Constants live in rsa_defines.svh; this package holds only types.
package rsa_pkg;

  typedef struct packed {
    logic [7:0] conv_pair;
    logic [7:0] conv_reg;
    logic [3:0] rail_on;
    logic [7:0] rdata;
    logic rd_valid;
    logic wr_refused;
  } rsa_state_t;

endpackage

// ### rsa_match_if.sv
// Carries strobe fields and the current strobe to the decoder, and hits back.
// Used only between the top module and its strobe decoder.
`timescale 1ns/10ps

interface rsa_match_if;
  logic [3:0] buck_one_strobe_field;
  logic [3:0] buck_two_strobe_field;
  logic [3:0] buck_three_strobe_field;
  logic [3:0] linear_reg_one_strobe_field;
  logic strobe_valid;
  logic [3:0] strobe_num;
  logic [3:0] hit;

  modport ctrl (
    output buck_one_strobe_field,
    output buck_two_strobe_field,
    output buck_three_strobe_field,
    output linear_reg_one_strobe_field,
    output strobe_valid,
    output strobe_num,
    input hit
  );

  modport dec (
    input buck_one_strobe_field,
    input buck_two_strobe_field,
    input buck_three_strobe_field,
    input linear_reg_one_strobe_field,
    input strobe_valid,
    input strobe_num,
    output hit
  );
endinterface

// ### rsa_strobe_decode.sv
// Combinational decode of strobe fields against the issued strobe.
// Assumes fields and strobe are stable in the clock domain of the caller.
`timescale 1ns/10ps
`include "rsa_defines.svh"

module rsa_strobe_decode (
  // Fields in, hits out
  rsa_match_if.dec m
);

  // Strobe number that enables a rail; zero means no sequencer control
  function automatic logic [3:0] rsa_strobe_of(
    input logic [3:0] field,
    input logic is_ldo
  );
    logic [3:0] s;
    s = field;
    if (!is_ldo)
    begin
      s = {1'b0, field[2:0]}; // see RULE8
    end
    else if (field == `RSA_CODE_NONE_8 || field == `RSA_CODE_NONE_9)
    begin
      s = `RSA_CODE_NONE; // see RULE3
    end
    return s;
  endfunction

  // Strobe zero is never issued as a match, so code zero never enables
  function automatic logic rsa_hit(
    input logic [3:0] field,
    input logic is_ldo,
    input logic valid,
    input logic [3:0] num
  );
    logic [3:0] s;
    s = rsa_strobe_of(field, is_ldo);
    return valid && (s != `RSA_CODE_NONE) && (s == num); // see RULE1
  endfunction

  always_comb
  begin
    // Buck converters: strobes one to seven
    m.hit[`RSA_RAIL_BUCK1] = rsa_hit(m.buck_one_strobe_field, 1'b0,
      m.strobe_valid, m.strobe_num); // see RULE2
    m.hit[`RSA_RAIL_BUCK2] = rsa_hit(m.buck_two_strobe_field, 1'b0,
      m.strobe_valid, m.strobe_num);
    m.hit[`RSA_RAIL_BUCK3] = rsa_hit(m.buck_three_strobe_field, 1'b0,
      m.strobe_valid, m.strobe_num);
    // Linear regulator: also ten to fifteen, fifteen with system supply
    m.hit[`RSA_RAIL_LINREG] = rsa_hit(m.linear_reg_one_strobe_field, 1'b1,
      m.strobe_valid, m.strobe_num); // see RULE4 see RULE5 see RULE9
  end

endmodule

// ### rsa_rail_strobe_assignment.sv
// Strobe assignment registers for three buck converters and one linear
// regulator, and the rail enables they produce as strobes are issued.
// Assumes register accesses, password state and strobes are synchronous
// to core_clk; the password check itself is done outside this block.
`timescale 1ns/10ps
`include "rsa_defines.svh"

// Operation
// RULE1: Field value zero leaves the rail out of sequencer control.
// RULE2: Field values one to seven enable the rail at that strobe.
// RULE3: Regulator field values eight and nine mean no sequencer control.
// RULE4: Regulator field value fourteen enables the rail at strobe fourteen.
// RULE5: Regulator field fifteen enables at strobe fifteen, with system supply.
// RULE6: Buck one and two fields sit at 0x19, writable only with password.
// RULE7: Buck three and regulator fields at 0x1A, writable only with password.
// RULE8: Converter field top bits are read-only, limiting them to strobes 1-7.
// RULE9: Regulator field values ten to thirteen enable at matching strobe.
module rsa_rail_strobe_assignment #(
  parameter logic [7:0] CONV_PAIR_RESET = `RSA_RESET_CONV_PAIR,
  parameter logic [7:0] CONV_REG_RESET = `RSA_RESET_CONV_REG
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic password_ok,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  output logic reg_wr_refused,
  // Sequencer strobes
  input wire logic strobe_valid,
  input wire logic [3:0] strobe_num,
  input wire logic seq_clear,
  // Rail enables
  output logic [3:0] rail_on
);

  rsa_pkg::rsa_state_t st;
  rsa_pkg::rsa_state_t next_st;
  rsa_match_if m ();
  logic addr_pair;
  logic addr_reg;

  assign m.buck_one_strobe_field = st.conv_pair[`RSA_HI_MSB:`RSA_HI_LSB];
  assign m.buck_two_strobe_field = st.conv_pair[`RSA_LO_MSB:`RSA_LO_LSB];
  assign m.buck_three_strobe_field = st.conv_reg[`RSA_HI_MSB:`RSA_HI_LSB];
  assign m.linear_reg_one_strobe_field =
    st.conv_reg[`RSA_LO_MSB:`RSA_LO_LSB];
  assign m.strobe_valid = strobe_valid;
  assign m.strobe_num = strobe_num;

  rsa_strobe_decode u_decode (
    .m (m.dec)
  );

  assign addr_pair = (reg_addr == `RSA_ADDR_CONV_PAIR);
  assign addr_reg = (reg_addr == `RSA_ADDR_CONV_REG);

  always_comb
  begin
    next_st = st;
    next_st.rd_valid = 1'b0;
    next_st.wr_refused = 1'b0;
    // Password-gated writes; read-only bits stay zero
    if (reg_wr && (addr_pair || addr_reg))
    begin
      if (!password_ok)
      begin
        next_st.wr_refused = 1'b1;
      end
      else if (addr_pair)
      begin
        next_st.conv_pair = reg_wdata & `RSA_MASK_CONV_PAIR; // see RULE6
      end
      else
      begin
        next_st.conv_reg = reg_wdata & `RSA_MASK_CONV_REG; // see RULE7
      end
    end
    // Reads return the value held before any same-cycle write
    if (reg_rd)
    begin
      next_st.rd_valid = 1'b1;
      if (addr_pair)
      begin
        next_st.rdata = st.conv_pair;
      end
      else if (addr_reg)
      begin
        next_st.rdata = st.conv_reg;
      end
      else
      begin
        next_st.rdata = `RSA_UNMAPPED_DATA;
      end
    end
    // Strobe hits set rails; a hit wins over a same-cycle clear
    if (seq_clear)
    begin
      next_st.rail_on = 4'h0;
    end
    next_st.rail_on = next_st.rail_on | m.hit; // see RULE2
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st.conv_pair <= CONV_PAIR_RESET & `RSA_MASK_CONV_PAIR; // see RULE8
      st.conv_reg <= CONV_REG_RESET & `RSA_MASK_CONV_REG;
      st.rail_on <= 4'h0;
      st.rdata <= 8'h00;
      st.rd_valid <= 1'b0;
      st.wr_refused <= 1'b0;
    end
    else if (clk_en)
    begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign reg_rd_valid = st.rd_valid;
  assign reg_wr_refused = st.wr_refused;
  assign rail_on = st.rail_on;

  // Checks
  a_zero_stays_off: assert property ( // see RULE1
    @(posedge core_clk) disable iff (!reset_n)
    clk_en && st.conv_pair[7:4] == 4'h0 && !st.rail_on[0]
    |=> !st.rail_on[0])
    else $error("buck one enabled with zero field");

  a_strobe_match_on: assert property ( // see RULE2
    @(posedge core_clk) disable iff (!reset_n)
    clk_en && strobe_valid && st.conv_pair[3:0] != 4'h0 &&
    st.conv_pair[3:0] == strobe_num |=> st.rail_on[1])
    else $error("buck two not enabled at its strobe");

  a_ldo_none_codes: assert property ( // see RULE3
    @(posedge core_clk) disable iff (!reset_n)
    clk_en && (st.conv_reg[3:0] == 4'h8 || st.conv_reg[3:0] == 4'h9) &&
    !st.rail_on[3] |=> !st.rail_on[3])
    else $error("regulator enabled with code eight or nine");

  a_ldo_fourteen_on: assert property ( // see RULE4
    @(posedge core_clk) disable iff (!reset_n)
    clk_en && strobe_valid && strobe_num == 4'hE &&
    st.conv_reg[3:0] == 4'hE |=> st.rail_on[3])
    else $error("regulator not enabled at strobe fourteen");

  a_ldo_fifteen_on: assert property ( // see RULE5
    @(posedge core_clk) disable iff (!reset_n)
    clk_en && strobe_valid && strobe_num == 4'hF &&
    st.conv_reg[3:0] == 4'hF |=> st.rail_on[3])
    else $error("regulator not enabled at strobe fifteen");

  a_pair_write_gate: assert property ( // see RULE6
    @(posedge core_clk) disable iff (!reset_n)
    clk_en && reg_wr && reg_addr == 8'h19 && !password_ok
    |=> $stable(st.conv_pair) && reg_wr_refused)
    else $error("unprotected write changed register 0x19");

  a_reg_write_take: assert property ( // see RULE7
    @(posedge core_clk) disable iff (!reset_n)
    clk_en && reg_wr && reg_addr == 8'h1A && password_ok
    |=> st.conv_reg == ($past(reg_wdata) & 8'h7F))
    else $error("protected write to 0x1A not taken");

  a_msb_read_only: assert property ( // see RULE8
    @(posedge core_clk) disable iff (!reset_n)
    !st.conv_pair[7] && !st.conv_pair[3] && !st.conv_reg[7])
    else $error("converter field top bit set");

  a_ldo_ten_thirteen: assert property ( // see RULE9
    @(posedge core_clk) disable iff (!reset_n)
    clk_en && strobe_valid && strobe_num >= 4'hA && strobe_num <= 4'hD &&
    st.conv_reg[3:0] == strobe_num |=> st.rail_on[3])
    else $error("regulator not enabled at strobe ten to thirteen");

  a_rise_needs_strobe: assert property ( // see RULE2
    @(posedge core_clk) disable iff (!reset_n)
    !(clk_en && strobe_valid)
    |=> (st.rail_on & ~$past(st.rail_on)) == 4'h0)
    else $error("rail enabled without an issued strobe");

  a_buck_three_high: assert property ( // see RULE8
    @(posedge core_clk) disable iff (!reset_n)
    clk_en && strobe_valid && strobe_num[3] && !st.rail_on[2]
    |=> !st.rail_on[2])
    else $error("buck three enabled at strobe above seven");

  a_read_pair_data: assert property ( // see RULE6
    @(posedge core_clk) disable iff (!reset_n)
    clk_en && reg_rd && reg_addr == 8'h19
    |=> reg_rd_valid && reg_rdata == $past(st.conv_pair))
    else $error("read of 0x19 returned wrong data");

  a_freeze_holds: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !clk_en |=> st == $past(st))
    else $error("state changed while clock enable low");

  c_ldo_fifteen: cover property (
    @(posedge core_clk) disable iff (!reset_n)
    clk_en && strobe_valid && strobe_num == 4'hF && m.hit[3]);

  c_refused_write: cover property (
    @(posedge core_clk) disable iff (!reset_n)
    reg_wr_refused);

  c_all_rails_on: cover property (
    @(posedge core_clk) disable iff (!reset_n)
    rail_on == 4'hF);

  c_frozen_strobe: cover property (
    @(posedge core_clk) disable iff (!reset_n)
    !clk_en && strobe_valid);

endmodule

// ### rsa_host_model.sv
// Host model: a bus master on the byte register port.
// Assumes the bench calls access at a rising edge of core_clk.
`timescale 1ns/10ps
module rsa_host_model (
  // Clock
  input wire logic core_clk,
  // Register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic password_ok
);
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    password_ok = 1'b0;
  end

  // One access, then an idle edge
  task automatic access(input logic wr, input logic [7:0] a,
                        input logic [7:0] d, input logic pw);
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_addr <= a;
    reg_wdata <= d;
    password_ok <= pw;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    password_ok <= 1'b0;
    @(posedge core_clk);
  endtask
endmodule

// ### rail_strobe_assignment_bench.sv
// Self-checking bench for the rail strobe assignment block.
// Assumes rsa_host_model drives the register port.
`timescale 1ns/10ps
`include "rsa_defines.svh"
module rail_strobe_assignment_bench;
  logic core_clk;
  logic reset_n;
  logic clk_en;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic password_ok;
  logic [7:0] reg_rdata;
  logic reg_rd_valid;
  logic reg_wr_refused;
  logic strobe_valid;
  logic [3:0] strobe_num;
  logic seq_clear;
  logic [3:0] rail_on;
  logic [7:0] exp_q[$];
  integer num_errors = 0;
  integer n_tests = 0;
  integer n_refused = 0;
  integer cycles = 0;
  integer seed = 68;
  logic [7:0] pair;
  logic [3:0] want;

  rsa_rail_strobe_assignment i_rsa_rail_strobe_assignment (
    .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .password_ok(password_ok),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .reg_wr_refused(reg_wr_refused), .strobe_valid(strobe_valid),
    .strobe_num(strobe_num), .seq_clear(seq_clear), .rail_on(rail_on)
  );

  rsa_host_model i_rsa_host_model (
    .core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .password_ok(password_ok)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic pw);
    i_rsa_host_model.access(1'b1, a, d, pw);
  endtask

  // Expected read data is noted before the request goes out
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    exp_q.push_back(exp);
    i_rsa_host_model.access(1'b0, a, 8'h00, 1'b0);
  endtask

  task automatic fire(input logic [3:0] n);
    strobe_valid <= 1'b1;
    strobe_num <= n;
    @(posedge core_clk);
    strobe_valid <= 1'b0;
    strobe_num <= ~n;
    @(posedge core_clk);
  endtask

  // Output watcher and hang limit
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      num_errors++;
      give_verdict();
    end
    if (reg_wr_refused === 1'b1)
      n_refused++;
    if (reg_rd_valid === 1'b1)
      check(reg_rdata, exp_q.pop_front());
  end

  initial
  begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    strobe_valid = 1'b0;
    strobe_num = 4'h0;
    seq_clear = 1'b0;
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    rd(`RSA_ADDR_CONV_PAIR, `RSA_RESET_CONV_PAIR);
    rd(`RSA_ADDR_CONV_REG, `RSA_RESET_CONV_REG);
    rd(8'h20, `RSA_UNMAPPED_DATA);
    wr(`RSA_ADDR_CONV_PAIR, 8'h00, 1'b0);
    rd(`RSA_ADDR_CONV_PAIR, `RSA_RESET_CONV_PAIR);
    wr(`RSA_ADDR_CONV_PAIR, 8'hFF, 1'b1);
    rd(`RSA_ADDR_CONV_PAIR, 8'h77);
    fire(4'h0);
    check({4'h0, rail_on}, 8'h00);
    for (int v = 0; v < 16; v++)
    begin
      pair = 8'($random(seed));
      wr(`RSA_ADDR_CONV_PAIR, pair, 1'b1);
      wr(`RSA_ADDR_CONV_REG, {v[3:0], v[3:0]}, 1'b1);
      rd(`RSA_ADDR_CONV_REG, {1'b0, v[2:0], v[3:0]});
      seq_clear <= 1'b1;
      @(posedge core_clk);
      seq_clear <= 1'b0;
      @(posedge core_clk);
      check({4'h0, rail_on}, 8'h00);
      fire(v[3:0]);
      want[0] = v != 0 && pair[6:4] == v;
      want[1] = v != 0 && pair[2:0] == v;
      want[2] = v != 0 && v < 8;
      want[3] = v != 0 && v != 8 && v != 9;
      check({4'h0, rail_on}, {4'h0, want});
    end
    // Frozen strobe is ignored; a hit wins over a same-cycle clear
    wr(`RSA_ADDR_CONV_PAIR, 8'h00, 1'b1);
    wr(`RSA_ADDR_CONV_REG, 8'h0E, 1'b1);
    seq_clear <= 1'b1;
    @(posedge core_clk);
    seq_clear <= 1'b0;
    clk_en <= 1'b0;
    fire(4'hE);
    check({4'h0, rail_on}, 8'h00);
    clk_en <= 1'b1;
    seq_clear <= 1'b1;
    strobe_valid <= 1'b1;
    strobe_num <= 4'hE;
    @(posedge core_clk);
    seq_clear <= 1'b0;
    strobe_valid <= 1'b0;
    @(posedge core_clk);
    check({4'h0, rail_on}, 8'h08);
    // Mid-run reset restores defaults and drops rails
    reset_n <= 1'b0;
    @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    check({4'h0, rail_on}, 8'h00);
    rd(`RSA_ADDR_CONV_REG, `RSA_RESET_CONV_REG);
    repeat (2) @(posedge core_clk);
    check(8'(exp_q.size()), 8'h00);
    check(8'(n_refused), 8'h01);
    give_verdict();
  end
endmodule
